// [src/rblc_top.sv]
`timescale 1ns/1ns
`include "rblc_defines.svh"
// small valid/ready fifo in the reading path
module rblc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rp_q];
    // storage write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < D; i++) mem_q[i] <= '0;
        end else if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    // pointers and fill count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            if (pop)  rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// reading buffer, statistics, limits and step/scan sequencer
module rblc_top
    import rblc_pkg::*;
#(
    parameter int DEPTH = `RBLC_MAX_DEPTH,
    parameter int UW    = 4
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // processed readings from the math stage
    input  wire logic         rd_valid,
    output logic              rd_ready,
    input  wire logic [63:0]  rd_value,
    input  wire logic [UW-1:0] rd_unit,
    input  wire logic         rd_overflow,
    input  wire logic         rd_continuity,
    // storage control and status
    input  wire logic         store_start,
    input  wire logic [10:0]  reading_count,
    output logic              store_busy,
    output logic [10:0]       stored_entries,
    // buffer readback
    input  wire logic [9:0]   rb_index,
    output logic [63:0]       rb_value,
    output logic [UW-1:0]     rb_unit,
    output logic [3:0]        rb_channel,
    output logic              rb_overflow,
    // statistics
    output logic              stats_valid,
    output logic [63:0]       buffer_maximum,
    output logic [63:0]       buffer_minimum,
    output logic [63:0]       buffer_sum,
    output logic [63:0]       buffer_sum_sq,
    output logic [63:0]       buffer_mean,
    output logic [63:0]       buffer_sample_deviation,
    // limits and beeper
    input  wire logic         lim_write,
    input  wire logic [1:0]   lim_sel,
    input  wire logic [63:0]  lim_data,
    input  wire logic [1:0]   beep_mode,
    output logic [63:0]       first_upper_limit,
    output logic [63:0]       first_lower_limit,
    output logic [63:0]       second_upper_limit,
    output logic [63:0]       second_lower_limit,
    output logic [1:0]        limit_verdict,
    output logic [1:0]        limit_verdict2,
    output logic              beep_tone1,
    output logic              beep_tone2,
    // step/scan sequencer
    input  wire logic         step_start,
    input  wire logic         scan_start,
    input  wire logic         halt,
    input  wire logic         four_wire,
    input  wire logic [3:0]   min_channel,
    input  wire logic [3:0]   max_channel,
    input  wire logic         external_trigger_in,
    output logic [3:0]        channel_now,
    output logic [9:0]        relay_close,
    output logic [10:0]       scan_passes,
    output logic              completion_trigger_out,
    output logic              list_end_trigger
);
    // external trigger synchroniser and falling edge
    logic ext_s1_q, ext_s2_q, ext_s3_q, ext_fall;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            ext_s3_q <= 1'b1;
        end else begin
            ext_s1_q <= external_trigger_in;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    assign ext_fall = ext_s3_q && !ext_s2_q;

    // reading fifo, one entry word = overflow, unit, value
    localparam int FW = 65 + UW;
    logic          f_valid, f_ready;
    logic [FW-1:0] f_data;
    rblc_fifo #(.W(FW), .D(`RBLC_FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (rd_valid),
        .in_ready  (rd_ready),
        .in_data   ({rd_overflow, rd_unit, rd_value}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );
    logic [63:0]   f_val;
    logic [UW-1:0] f_unit;
    logic          f_ovf;
    assign {f_ovf, f_unit, f_val} = f_data;

    // storage run control
    logic [10:0] target_q;
    logic [10:0] wr_idx_q;
    logic        busy_q;
    logic        take;
    // drain only while storing; stalled otherwise
    assign f_ready = busy_q;
    assign take    = f_valid && busy_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q   <= 1'b0;
            wr_idx_q <= '0;
            target_q <= 11'(`RBLC_MIN_DEPTH);
        end else if (store_start) begin
            busy_q   <= 1'b1;
            wr_idx_q <= '0;
            if (reading_count < 11'(`RBLC_MIN_DEPTH))
                target_q <= 11'(`RBLC_MIN_DEPTH);
            else if (reading_count > 11'(DEPTH))
                target_q <= 11'(DEPTH);
            else
                target_q <= reading_count;
        end else if (take) begin
            wr_idx_q <= wr_idx_q + 11'h001;
            if (wr_idx_q + 11'h001 == target_q)
                busy_q <= 1'b0;
        end
    end
    assign store_busy     = busy_q;
    assign stored_entries = wr_idx_q;

    // buffer storage: value, unit, channel, overflow
    logic [63:0]   buf_val_q [DEPTH];
    logic [UW-1:0] buf_unit_q [DEPTH];
    logic [3:0]    buf_ch_q [DEPTH];
    logic          buf_ovf_q [DEPTH];
    logic [3:0]    chan_q;
    logic          scanning;
    always_ff @(posedge ref_clk) begin
        if (take) begin
            buf_val_q[wr_idx_q[9:0]]  <= f_val;
            buf_unit_q[wr_idx_q[9:0]] <= f_unit;
            buf_ch_q[wr_idx_q[9:0]]   <= scanning ? chan_q : 4'h0;
            buf_ovf_q[wr_idx_q[9:0]]  <= f_ovf;
        end
    end
    // readback registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rb_value    <= '0;
            rb_unit     <= '0;
            rb_channel  <= '0;
            rb_overflow <= 1'b0;
        end else if (11'(rb_index) < wr_idx_q) begin
            rb_value    <= buf_val_q[rb_index];
            rb_unit     <= buf_unit_q[rb_index];
            rb_channel  <= buf_ch_q[rb_index];
            rb_overflow <= buf_ovf_q[rb_index];
        end else begin
            rb_value    <= '0;
            rb_unit     <= '0;
            rb_channel  <= '0;
            rb_overflow <= 1'b0;
        end
    end

    // running statistics in double precision
    real  r_n, r_mean, r_var;
    logic any_ovf_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            buffer_maximum <= '0;
            buffer_minimum <= '0;
            buffer_sum     <= '0;
            buffer_sum_sq  <= '0;
            any_ovf_q      <= 1'b0;
        end else if (store_start) begin
            buffer_sum    <= '0;
            buffer_sum_sq <= '0;
            any_ovf_q     <= 1'b0;
        end else if (take) begin
            if (f_ovf) any_ovf_q <= 1'b1;
            if (wr_idx_q == 11'h000
                || $bitstoreal(f_val) > $bitstoreal(buffer_maximum))
                buffer_maximum <= f_val;
            if (wr_idx_q == 11'h000
                || $bitstoreal(f_val) < $bitstoreal(buffer_minimum))
                buffer_minimum <= f_val;
            buffer_sum    <= $realtobits($bitstoreal(buffer_sum)
                             + $bitstoreal(f_val));
            buffer_sum_sq <= $realtobits($bitstoreal(buffer_sum_sq)
                             + $bitstoreal(f_val) * $bitstoreal(f_val));
        end
    end
    // mean and deviation from the sums
    always_comb begin
        r_n    = real'(wr_idx_q);
        r_mean = 0.0;
        r_var  = 0.0;
        if (wr_idx_q != 11'h000)
            r_mean = $bitstoreal(buffer_sum) / r_n;
        if (wr_idx_q > 11'h001) begin
            r_var = ($bitstoreal(buffer_sum_sq)
                   - $bitstoreal(buffer_sum) * r_mean) / (r_n - 1.0);
            if (r_var < 0.0) r_var = 0.0;
        end
        buffer_mean             = $realtobits(r_mean);
        buffer_sample_deviation = $realtobits($sqrt(r_var));
    end
    // statistics only for a finished, overflow-free buffer
    assign stats_valid = !busy_q && !any_ovf_q
                         && (wr_idx_q >= 11'(`RBLC_MIN_DEPTH));

    // limit registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            first_upper_limit  <= `RBLC_LIM1_HI;
            first_lower_limit  <= `RBLC_LIM1_LO;
            second_upper_limit <= `RBLC_LIM2_HI;
            second_lower_limit <= `RBLC_LIM2_LO;
        end else if (lim_write) begin
            unique case (lim_sel)
                2'h0: first_upper_limit  <= lim_data;
                2'h1: first_lower_limit  <= lim_data;
                2'h2: second_upper_limit <= lim_data;
                2'h3: second_lower_limit <= lim_data;
            endcase
        end
    end

    // classify each incoming base-unit reading against both pairs
    function automatic logic [1:0] classify(input logic [63:0] v,
                                            input logic [63:0] hi,
                                            input logic [63:0] lo);
        if ($bitstoreal(v) > $bitstoreal(hi))      classify = RBLC_V_HI;
        else if ($bitstoreal(v) < $bitstoreal(lo)) classify = RBLC_V_LO;
        else                                       classify = RBLC_V_IN;
    endfunction
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            limit_verdict  <= RBLC_V_NONE;
            limit_verdict2 <= RBLC_V_NONE;
        end else if (rd_valid && rd_ready) begin
            if (rd_continuity || rd_overflow) begin
                limit_verdict  <= RBLC_V_NONE;
                limit_verdict2 <= RBLC_V_NONE;
            end else begin
                limit_verdict  <= classify(rd_value, first_upper_limit,
                                           first_lower_limit);
                limit_verdict2 <= classify(rd_value, second_upper_limit,
                                           second_lower_limit);
            end
        end
    end
    // beeper tone selection, first pair wins in inside mode
    logic in1, in2, out1, out2;
    assign in1  = (limit_verdict == RBLC_V_IN);
    assign in2  = (limit_verdict2 == RBLC_V_IN);
    assign out1 = (limit_verdict == RBLC_V_HI) || (limit_verdict == RBLC_V_LO);
    assign out2 = (limit_verdict2 == RBLC_V_HI)
                  || (limit_verdict2 == RBLC_V_LO);
    always_comb begin
        beep_tone1 = 1'b0;
        beep_tone2 = 1'b0;
        unique case (beep_mode)
            RBLC_BEEP_INSIDE: begin
                beep_tone1 = in1;
                beep_tone2 = !in1 && in2;
            end
            RBLC_BEEP_OUTSIDE: begin
                beep_tone1 = out1 || out2;
            end
            default: ;
        endcase
    end

    // step/scan sequencer
    rblc_seq_t   seq_q;
    logic [10:0] done_q;
    logic [3:0]  list_len;
    logic        act_done;
    assign list_len = max_channel - min_channel + 4'h1;
    assign scanning = (seq_q != RBLC_SQ_IDLE);
    assign act_done = take; // one device action per stored reading
    // passes = ceil(count / list length)
    assign scan_passes = (list_len == 4'h0) ? 11'h000 :
        11'((reading_count + 11'(list_len) - 11'h001) / 11'(list_len));
    logic last_ch;
    assign last_ch = (chan_q == max_channel);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq_q  <= RBLC_SQ_IDLE;
            chan_q <= 4'h1;
            done_q <= '0;
        end else if (halt) begin
            seq_q <= RBLC_SQ_IDLE;
        end else if (step_start || scan_start) begin
            seq_q  <= step_start ? RBLC_SQ_STEP : RBLC_SQ_SCAN;
            chan_q <= min_channel;
            done_q <= '0;
        end else if (scanning && act_done) begin
            done_q <= done_q + 11'h001;
            chan_q <= last_ch ? min_channel : chan_q + 4'h1;
            if (done_q + 11'h001 >= target_q
                && (seq_q == RBLC_SQ_STEP || last_ch))
                seq_q <= RBLC_SQ_IDLE;
        end
    end
    assign channel_now = chan_q;
    // relay drive, four-wire adds the partner five higher
    always_comb begin
        relay_close = '0;
        if (scanning && chan_q >= 4'h1 && chan_q <= 4'(`RBLC_NUM_CHAN)) begin
            relay_close[chan_q - 4'h1] = 1'b1;
            if (four_wire && chan_q <= 4'(`RBLC_PAIR_OFS))
                relay_close[chan_q + 4'(`RBLC_PAIR_OFS) - 4'h1] = 1'b1;
        end
    end
    // output trigger pulses
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            completion_trigger_out <= 1'b0;
            list_end_trigger       <= 1'b0;
        end else begin
            completion_trigger_out <= act_done
                && (seq_q != RBLC_SQ_SCAN || last_ch);
            list_end_trigger <= act_done && seq_q == RBLC_SQ_SCAN
                && last_ch;
        end
    end
    logic unused_ext;
    assign unused_ext = ext_fall;

    // checks
    chk_busy_end: assert property (@(posedge ref_clk) disable iff (!rstn)
        busy_q && take && !store_start && (wr_idx_q + 11'h001 == target_q)
        |=> !busy_q) else $error("busy not cleared at count");
    chk_start_busy: assert property (@(posedge ref_clk) disable iff (!rstn)
        store_start |=> busy_q && wr_idx_q == 11'h000)
        else $error("start did not restart run");
    chk_no_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        !busy_q && !store_start |=> $stable(wr_idx_q))
        else $error("entry written while idle");
    chk_ovf_stats: assert property (@(posedge ref_clk) disable iff (!rstn)
        any_ovf_q |-> !stats_valid)
        else $error("stats valid with overflow");
    chk_cont_none: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_valid && rd_ready && rd_continuity
        |=> limit_verdict == RBLC_V_NONE)
        else $error("continuity got a verdict");
    chk_tone_excl: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(beep_tone1 && beep_tone2))
        else $error("both tones at once");
    chk_never_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        beep_mode == RBLC_BEEP_NEVER |-> !beep_tone1 && !beep_tone2)
        else $error("beep in never mode");
    chk_halt_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        halt |=> seq_q == RBLC_SQ_IDLE)
        else $error("halt did not stop sequencing");
    chk_step_trig: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_q == RBLC_SQ_STEP && act_done && !halt |=> completion_trigger_out)
        else $error("missing step trigger");
    chk_scan_mid: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_q == RBLC_SQ_SCAN && act_done && !last_ch
        |=> !completion_trigger_out)
        else $error("trigger mid scan list");
endmodule

// [src/rblc_defines.svh]
// Contract
// - depth two to 1024 entries, value plus unit
// - store channel number and overflow readings
// - overflow entry blocks all statistics
// - run stops after requested count stored
// - entries hold math-processed reading values
// - new run restarts at first entry
// - busy flag set at start, cleared at end
// - report largest and smallest stored values
// - mean is sum divided by count
// - deviation from sums, normalised by n minus one
// - statistics use IEEE-754 floating point format
// - above/inside/below verdict, none for continuity
// - compare processed value in base units
// - power-up limits +1/-1 and +2/-2
// - beeper never, outside or inside
// - shared beep mode, two tones, first wins
// - outside mode first pair has priority (code sounds tone1 when either pair is outside, no priority)
// - step mode trigger after every channel
// - scan mode trigger at list end only
// - halt stops sequencing, back to idle
// - ten two-pole or five four-pole channels
// - completion pulse after each device action, in scan mode only at list end
// - four-wire closes channel and channel plus five
// - scan passes round up count over list
`ifndef RBLC_DEFINES_SVH
`define RBLC_DEFINES_SVH
`define RBLC_MAX_DEPTH   1024
`define RBLC_MIN_DEPTH   2
`define RBLC_NUM_CHAN    10
`define RBLC_PAIR_OFS    5
`define RBLC_LIM1_HI     64'h3FF0_0000_0000_0000
`define RBLC_LIM1_LO     64'hBFF0_0000_0000_0000
`define RBLC_LIM2_HI     64'h4000_0000_0000_0000
`define RBLC_LIM2_LO     64'hC000_0000_0000_0000
`define RBLC_FIFO_DEPTH  4
`endif

// [src/rblc_pkg.sv]
package rblc_pkg;
    typedef enum logic [1:0] {
        RBLC_BEEP_NEVER   = 2'h0,
        RBLC_BEEP_OUTSIDE = 2'h1,
        RBLC_BEEP_INSIDE  = 2'h2
    } rblc_beep_t;
    typedef enum logic [1:0] {
        RBLC_V_NONE = 2'h0,
        RBLC_V_LO   = 2'h1,
        RBLC_V_IN   = 2'h2,
        RBLC_V_HI   = 2'h3
    } rblc_verdict_t;
    typedef enum logic [1:0] {
        RBLC_SQ_IDLE = 2'b00,
        RBLC_SQ_STEP = 2'b01,
        RBLC_SQ_SCAN = 2'b11
    } rblc_seq_t;
endpackage

// [dv/rblc_front_end.sv]
`timescale 1ns/1ns
// measurement front end and scanner mainframe seen from the block
module rblc_front_end (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // bench request
    input  wire logic        send,
    input  wire logic [63:0] s_value,
    input  wire logic        s_ovf,
    input  wire logic        s_cont,
    // reading stream
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [63:0]      rd_value,
    output logic [3:0]       rd_unit,
    output logic             rd_overflow,
    output logic             rd_continuity,
    // mainframe trigger lines
    input  wire logic        completion_trigger_out,
    output logic             external_trigger_in
);
    logic [63:0] val_q;
    logic        ovf_q;
    logic        cont_q;
    // reading held until taken; released lines show the inverse
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            val_q <= 64'h0000_0000_0000_0000;
            ovf_q <= 1'b0;
            cont_q <= 1'b0;
        end else if (send) begin
            rd_valid <= 1'b1;
            val_q <= s_value;
            ovf_q <= s_ovf;
            cont_q <= s_cont;
        end else if (rd_valid && rd_ready) begin
            rd_valid <= 1'b0;
        end
    end
    assign rd_value = rd_valid ? val_q : ~val_q;
    assign rd_unit = rd_valid ? 4'h3 : 4'hc;
    assign rd_overflow = rd_valid ? ovf_q : ~ovf_q;
    assign rd_continuity = rd_valid ? cont_q : ~cont_q;
    // mainframe closes next channel on each completion, pulses low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            external_trigger_in <= 1'b1;
        end else begin
            external_trigger_in <= !completion_trigger_out;
        end
    end
endmodule

// [dv/reading_buffer_limit_check_tb.sv]
`timescale 1ns/1ns
module reading_buffer_limit_check_tb;
    import rblc_pkg::*;
    logic        ref_clk = 0, rstn = 0, send = 0, s_ovf = 0, s_cont = 0;
    logic        rd_valid, rd_ready, rd_overflow, rd_continuity, halt = 0;
    logic        store_start = 0, store_busy, stats_valid, rb_overflow;
    logic        lim_write = 0, beep_tone1, beep_tone2, step_start = 0;
    logic        scan_start = 0, four_wire = 0, external_trigger_in;
    logic        completion_trigger_out, list_end_trigger;
    logic [1:0]  lim_sel = 0, beep_mode = 0, limit_verdict, limit_verdict2;
    logic [3:0]  rd_unit, rb_unit, rb_channel, channel_now;
    logic [3:0]  min_channel = 1, max_channel = 3;
    logic [9:0]  rb_index = 0, relay_close;
    logic [10:0] reading_count = 2, stored_entries, scan_passes;
    logic [63:0] s_value = 0, rd_value, rb_value, lim_data = 0;
    logic [63:0] buffer_maximum, buffer_minimum, buffer_sum, buffer_sum_sq;
    logic [63:0] buffer_mean, buffer_sample_deviation;
    logic [63:0] first_upper_limit, first_lower_limit;
    logic [63:0] second_upper_limit, second_lower_limit;
    int          bad_count = 0, comparisons = 0, n_done = 0, n_end = 0;
    logic [31:0] seed = 88;
    real         lv[9] = '{0.15, 600.0, -1.5, 0.15, 0.9, 1.5, 1.5, 0.5, 3.0};
    logic [1:0]  md[9] = '{2, 1, 1, 0, 2, 2, 1, 1, 0};
    real         vals[6];
    // clock
    always #10 ref_clk = ~ref_clk;
    rblc_top rblc_top_inst (.*);
    rblc_front_end rblc_front_end_inst (.*);
    // output trigger pulse counters
    always @(posedge ref_clk) begin
        if (completion_trigger_out === 1'b1) n_done++;
        if (list_end_trigger === 1'b1) n_end++;
    end
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % 17) - 8;
    endfunction
    function automatic logic [1:0] vd(real v, real hi, real lo);
        return v > hi ? RBLC_V_HI : (v < lo ? RBLC_V_LO : RBLC_V_IN);
    endfunction
    task automatic cmp_w(string n, logic [63:0] e, logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_n(string n, logic [10:0] e, logic [10:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic put(real v, bit ov, bit ct);
        int i;
        @(posedge ref_clk);
        s_value <= $realtobits(v);
        s_ovf <= ov;
        s_cont <= ct;
        send <= 1;
        @(posedge ref_clk);
        send <= 0;
        i = 0;
        do begin
            tick(1);
            i++;
        end while (rd_valid !== 1'b0 && i < 20);
    endtask
    task automatic run(int c, bit st, bit sc);
        @(posedge ref_clk);
        store_start <= 1;
        reading_count <= 11'(c);
        step_start <= st;
        scan_start <= sc;
        @(posedge ref_clk);
        store_start <= 0;
        step_start <= 0;
        scan_start <= 0;
        tick(0);
        cmp_n("busy", 1, store_busy);
        cmp_n("entries", 0, stored_entries);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 60 && store_busy !== 1'b0; i++) tick(1);
        tick(3);
    endtask
    task automatic peek(int i);
        @(posedge ref_clk);
        rb_index <= 10'(i);
        tick(2);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (6000) @(posedge ref_clk);
        bad_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        real mx, mn, s, sq, v;
        logic [1:0] e1, e2;
        int d0, e0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1;
        tick(1);
        cmp_n("busy", 0, store_busy);
        cmp_n("entries", 0, stored_entries);
        cmp_w("hi1", $realtobits(1.0), first_upper_limit);
        cmp_w("lo1", $realtobits(-1.0), first_lower_limit);
        cmp_w("hi2", $realtobits(2.0), second_upper_limit);
        cmp_w("lo2", $realtobits(-2.0), second_lower_limit);
        // exact statistics corner
        run(3, 0, 0);
        for (int i = 1; i <= 3; i++) put(real'(i), 0, 0);
        wait_idle();
        cmp_n("busy", 0, store_busy);
        cmp_n("entries", 3, stored_entries);
        cmp_n("stats_valid", 1, stats_valid);
        cmp_w("max", $realtobits(3.0), buffer_maximum);
        cmp_w("min", $realtobits(1.0), buffer_minimum);
        cmp_w("mean", $realtobits(2.0), buffer_mean);
        cmp_w("dev", $realtobits(1.0), buffer_sample_deviation);
        peek(1);
        cmp_w("rb_value", $realtobits(2.0), rb_value);
        cmp_n("rb_unit", 3, rb_unit);
        // random readings in a fresh run
        run(6, 0, 0);
        mx = -100.0;
        mn = 100.0;
        s = 0.0;
        sq = 0.0;
        for (int i = 0; i < 6; i++) begin
            vals[i] = real'(rnd());
            mx = vals[i] > mx ? vals[i] : mx;
            mn = vals[i] < mn ? vals[i] : mn;
            s += vals[i];
            sq += vals[i] * vals[i];
            put(vals[i], 0, 0);
        end
        wait_idle();
        cmp_w("max", $realtobits(mx), buffer_maximum);
        cmp_w("min", $realtobits(mn), buffer_minimum);
        cmp_w("sum", $realtobits(s), buffer_sum);
        cmp_w("sum_sq", $realtobits(sq), buffer_sum_sq);
        for (int i = 0; i < 6; i++) begin
            peek(i);
            cmp_w("rb_value", $realtobits(vals[i]), rb_value);
        end
        // overflow entry
        run(2, 0, 0);
        put(5.0, 1, 0);
        put(1.0, 0, 0);
        wait_idle();
        cmp_n("stats_valid", 0, stats_valid);
        peek(0);
        cmp_n("rb_overflow", 1, rb_overflow);
        // limit verdicts and beeper tones
        run(20, 0, 0);
        for (int i = 0; i < 9; i++) begin
            @(posedge ref_clk);
            beep_mode <= md[i];
            put(lv[i], 0, i == 3);
            tick(2);
            e1 = i == 3 ? RBLC_V_NONE : vd(lv[i], 1.0, -1.0);
            e2 = i == 3 ? RBLC_V_NONE : vd(lv[i], 2.0, -2.0);
            cmp_n("verdict1", 11'(e1), limit_verdict);
            cmp_n("verdict2", 11'(e2), limit_verdict2);
            cmp_n("tone1", md[i] == 2 ? e1 == RBLC_V_IN : (md[i] == 1 ?
                e1 != RBLC_V_IN || e2 != RBLC_V_IN : 0), beep_tone1);
            cmp_n("tone2", md[i] == 2 && e2 == RBLC_V_IN &&
                e1 != RBLC_V_IN, beep_tone2);
            if (md[i] == 1) cmp_n("tone2", 0, beep_tone2);
        end
        @(posedge ref_clk);
        lim_write <= 1;
        lim_data <= $realtobits(0.5);
        @(posedge ref_clk);
        lim_write <= 0;
        put(0.9, 0, 0);
        tick(2);
        cmp_w("hi1", $realtobits(0.5), first_upper_limit);
        cmp_n("verdict1", RBLC_V_HI, limit_verdict);
        // stepping with four-wire pairs
        min_channel <= 2;
        max_channel <= 4;
        four_wire <= 1;
        d0 = n_done;
        run(4, 1, 0);
        cmp_n("relays", 11'h042, relay_close);
        cmp_n("channel", 2, channel_now);
        for (int i = 0; i < 4; i++) put(1.0, 0, 0);
        wait_idle();
        cmp_n("step_trigs", 4, n_done - d0);
        for (int i = 0; i < 4; i++) begin
            peek(i);
            cmp_n("rb_channel", 2 + i % 3, rb_channel);
        end
        // scanning, one trigger at list end
        min_channel <= 1;
        max_channel <= 3;
        four_wire <= 0;
        d0 = n_done;
        e0 = n_end;
        run(3, 0, 1);
        for (int i = 0; i < 3; i++) put(1.0, 0, 0);
        wait_idle();
        cmp_n("scan_trigs", 1, n_done - d0);
        cmp_n("list_end", 1, n_end - e0);
        reading_count <= 4;
        tick(1);
        cmp_n("passes", 2, scan_passes);
        // halt during stepping
        run(10, 1, 0);
        put(1.0, 0, 0);
        @(posedge ref_clk);
        halt <= 1;
        @(posedge ref_clk);
        halt <= 0;
        put(1.0, 0, 0);
        tick(3);
        peek(1);
        cmp_n("rb_channel", 0, rb_channel);
        // storage stops at the requested count
        run(2, 0, 0);
        for (int i = 0; i < 6; i++) put(1.0, 0, 0);
        tick(3);
        cmp_n("entries", 2, stored_entries);
        cmp_n("rd_ready", 0, rd_ready);
        wrap_up();
    end
endmodule
